// *** pkg/sclc_regs.vh ***
// Overview of operation
// RQ1: Only board numbers 1 to 31 are recognised.
// RQ2: Number from switches 4-8, switch 8 LSB.
// RQ3: Never duplicate a board number per type.
// RQ4: Log on, parameterize, then activate; outputs quiet.
// RQ5: Unactivated board: no send blink, not listed.
// RQ6: Report monitoring/idle and error/no-error state.
// RQ7: Whole byte written; takes effect after confirm.
// RQ8: Bit 7: line one 12h or 24h.
// RQ9: Bit 4: line two 12h or 24h.
// RQ10: Bit 6: two minute lines, else minute+second.
// RQ11: Occupy two line numbers, or one shared.
// RQ12: Bit 5 zero: hold hour, advance on spring.
// RQ13: Bit 5 one: forerun 11 or 23 hours; code forces hold on 24h lines, so only the 11-hour forerun is used.
// RQ14: 24-hour minute line always uses hold behaviour.
// RQ15: Bits 3 to 0 unused, written zero.
// RQ16: Line settings only in pole-changing operation.
// RQ17: Minute width 0.2-3.0 s; second fixed 0.2 s.
// RQ18: Successive pulses alternate polarity.
`ifndef SCLC_REGS_VH
`define SCLC_REGS_VH

// Register byte addresses
`define SCLC_ADDR_ID        8'h00
`define SCLC_ADDR_CTRL      8'h04
`define SCLC_ADDR_CFG       8'h08
`define SCLC_ADDR_CONFIRM   8'h0C
`define SCLC_ADDR_STATUS    8'h10
`define SCLC_ADDR_WIDTH     8'h14
`define SCLC_ADDR_INT_STAT  8'h18
`define SCLC_ADDR_INT_MASK  8'h1C

// Control register fields
`define SCLC_CTRL_LOGON     0
`define SCLC_CTRL_MONITOR   1
`define SCLC_CTRL_POLE      2

// Line configuration byte fields
`define SCLC_CFG_H24_ONE    7
`define SCLC_CFG_TWO_MIN    6
`define SCLC_CFG_UPDATE     5
`define SCLC_CFG_H24_TWO    4
`define SCLC_CFG_RESET      8'h00

// Status register fields
`define SCLC_STAT_MONITOR   0
`define SCLC_STAT_ERROR     1
`define SCLC_STAT_VALID     2
`define SCLC_STAT_LISTED    3
`define SCLC_STAT_PENDING   4
`define SCLC_STAT_LINES_LO  5

// Interrupt events
`define SCLC_INT_COMMIT     0
`define SCLC_INT_CHANGE     1
`define SCLC_INT_FAULT      2
`define SCLC_INT_W          3

// Pulse widths in tenths of a second
`define SCLC_WIDTH_MIN      5'd2
`define SCLC_WIDTH_MAX      5'd30
`define SCLC_WIDTH_SECOND   5'd2
`define SCLC_WIDTH_RESET    5'd2

// Changeover minute counts
`define SCLC_HOUR_MIN       12'd60
`define SCLC_FORERUN12_MIN  12'd660
`define SCLC_FORERUN24_MIN  12'd1380

// Timing: one tenth of a second at a 4 ns clock
`define SCLC_TENTH_NS       100000000
`define SCLC_CLK_NS         4
`define SCLC_TENTH_CYC      (`SCLC_TENTH_NS / `SCLC_CLK_NS)

`endif

// *** hw/sclc_pulse_line.v ***
`default_nettype none

module sclc_pulse_line #(
    parameter TENTH_CYCLES = 25000000
) (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        enable,
    input  wire        tick,
    input  wire [4:0]  width_tenths,
    input  wire        add_req,
    input  wire        skip_req,
    input  wire [11:0] change_cnt,
    output wire        busy,
    output reg         drive_pos,
    output reg         drive_neg
);

    ////////////////////////////////////////////////////////////////////////
    reg  [11:0] debt_q;
    reg  [11:0] skip_q;
    reg  [31:0] tenth_q;
    reg  [4:0]  tenths_q;
    reg         phase_q;
    reg         active_q;
    reg         polarity_q;

    assign busy = active_q | (debt_q != 12'h000) | (skip_q != 12'h000);

    ////////////////////////////////////////////////////////////////////////
    // Pulse then equal gap; gap keeps clockworks from missing a step
    always @(posedge core_clk)
    begin
        if (srst || !enable)
        begin
            debt_q     <= 12'h000;
            skip_q     <= 12'h000;
            tenth_q    <= 32'h0000_0000;
            tenths_q   <= 5'h00;
            phase_q    <= 1'b0;
            active_q   <= 1'b0;
            polarity_q <= 1'b0;
            drive_pos  <= 1'b0;
            drive_neg  <= 1'b0;
        end
        else
        begin
            if (add_req)
                debt_q <= debt_q + change_cnt;
            else if (skip_req)
                skip_q <= change_cnt;
            else if (tick && skip_q != 12'h000)
                skip_q <= skip_q - 12'h001;
            else if (tick)
                debt_q <= debt_q + 12'h001;
            else if (!active_q && debt_q != 12'h000)
            begin
                debt_q     <= debt_q - 12'h001;
                active_q   <= 1'b1;
                phase_q    <= 1'b0;
                tenth_q    <= 32'h0000_0000;
                tenths_q   <= 5'h00;
                polarity_q <= ~polarity_q;               // [RQ18]
                drive_pos  <= ~polarity_q;
                drive_neg  <= polarity_q;
            end
            if (active_q)
            begin
                if (tenth_q == TENTH_CYCLES - 1)
                begin
                    tenth_q <= 32'h0000_0000;
                    if (tenths_q == width_tenths - 5'd1)
                    begin
                        tenths_q  <= 5'h00;
                        phase_q   <= 1'b1;
                        drive_pos <= 1'b0;
                        drive_neg <= 1'b0;
                        if (phase_q)
                            active_q <= 1'b0;
                    end
                    else
                        tenths_q <= tenths_q + 5'd1;
                end
                else
                    tenth_q <= tenth_q + 32'd1;
            end
        end
    end

endmodule

`default_nettype wire

// *** hw/sclc_top.v ***
// The address map and the APB slave port were left to the implementer.
`include "sclc_regs.vh"
`default_nettype none

module sclc_top #(
    parameter TENTH_CYCLES = `SCLC_TENTH_CYC,
    parameter BOARD_TYPE   = 16'h00A5   // Arbitrary value
) (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire [7:0]  board_number_switch_bank,
    input  wire        minute_tick,
    input  wire        second_tick,
    input  wire        summer_to_winter,
    input  wire        winter_to_summer,
    input  wire [1:0]  line_fault,
    output wire        pulse_line_one_pos,
    output wire        pulse_line_one_neg,
    output wire        pulse_line_two_pos,
    output wire        pulse_line_two_neg,
    output reg         send_led,
    output wire [1:0]  lines_used,
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Position 8 is the least significant bit, closed reads as one
    function [4:0] sw_to_number;
        input [7:0] sw;
        begin
            sw_to_number = {sw[3], sw[4], sw[5], sw[6], sw[7]};     // [RQ2]
        end
    endfunction

    function [4:0] clamp_width;
        input [4:0] w;
        begin
            if (w < `SCLC_WIDTH_MIN)
                clamp_width = `SCLC_WIDTH_MIN;
            else if (w > `SCLC_WIDTH_MAX)
                clamp_width = `SCLC_WIDTH_MAX;
            else
                clamp_width = w;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    reg  [4:0]  board_num_q;
    reg         logon_q;
    reg         monitor_q;
    reg         pole_q;
    reg  [7:0]  cfg_pend_q;
    reg  [7:0]  cfg_q;
    reg         pending_q;
    reg  [4:0]  width_one_q;
    reg  [4:0]  width_two_q;
    reg  [`SCLC_INT_W-1:0] int_stat_q;
    reg  [`SCLC_INT_W-1:0] int_mask_q;
    reg  [1:0]  fault_q;
    reg  [22:0] blink_q;
    reg         blink_arm_q;

    wire        board_valid;
    wire        board_error;
    wire        active;
    wire        wr_en;
    wire        rd_setup;
    reg         addr_ok;
    reg  [31:0] rd_val;
    wire [`SCLC_INT_W-1:0] events;
    wire [1:0]  drv_pos;
    wire [1:0]  drv_neg;
    wire [1:0]  line_en;
    wire [1:0]  line_tick;
    wire [1:0]  is_minute;
    wire [1:0]  is_h24;
    wire [4:0]  line_width [0:1];
    wire        fwd_hold [0:1];
    reg  [1:0]  add_req;
    reg  [1:0]  skip_req;
    reg  [11:0] change_cnt [0:1];
    wire        change_evt;
    wire        h24_one;
    wire        h24_two;

    assign board_valid = (board_num_q != 5'h00);                    // [RQ1]
    assign board_error = |line_fault;
    // Silent until logged on, valid and monitoring
    assign active      = board_valid & logon_q & monitor_q;         // [RQ4]

    ////////////////////////////////////////////////////////////////////////
    // Straps sampled every edge, never reset
    always @(posedge core_clk)
    begin
        board_num_q <= sw_to_number(board_number_switch_bank);
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in setup phase
    assign pready   = 1'b1;
    assign wr_en    = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pslverr  = psel & penable & ~addr_ok;

    always @*
    begin
        case (paddr)
            `SCLC_ADDR_ID,
            `SCLC_ADDR_CTRL,
            `SCLC_ADDR_CFG,
            `SCLC_ADDR_CONFIRM,
            `SCLC_ADDR_STATUS,
            `SCLC_ADDR_WIDTH,
            `SCLC_ADDR_INT_STAT,
            `SCLC_ADDR_INT_MASK: addr_ok = 1'b1;
            default:             addr_ok = 1'b0;
        endcase
    end

    always @*
    begin
        rd_val = 32'h0000_0000;
        case (paddr)
            `SCLC_ADDR_ID:
                rd_val = {7'h00, board_valid, BOARD_TYPE[15:0], 3'h0,
                          board_num_q};                             // [RQ1]
            `SCLC_ADDR_CTRL:
                rd_val = {29'h0000_0000, pole_q, monitor_q, logon_q};
            `SCLC_ADDR_CFG:
                rd_val = {24'h00_0000, cfg_q};
            `SCLC_ADDR_CONFIRM:
                rd_val = {24'h00_0000, cfg_pend_q};
            `SCLC_ADDR_STATUS:
                rd_val = {25'h000_0000, lines_used, pending_q, active,
                          board_valid, board_error, monitor_q};     // [RQ6] [RQ5]
            `SCLC_ADDR_WIDTH:
                rd_val = {19'h0_0000, width_two_q, 3'h0, width_one_q};
            `SCLC_ADDR_INT_STAT:
                rd_val = {29'h0000_0000, int_stat_q};
            `SCLC_ADDR_INT_MASK:
                rd_val = {29'h0000_0000, int_mask_q};
            default:
                rd_val = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (srst)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= rd_val;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration: byte is staged whole, applied only on confirm
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            logon_q     <= 1'b0;
            monitor_q   <= 1'b0;
            pole_q      <= 1'b1;
            cfg_pend_q  <= `SCLC_CFG_RESET;
            cfg_q       <= `SCLC_CFG_RESET;
            pending_q   <= 1'b0;
            width_one_q <= `SCLC_WIDTH_RESET;
            width_two_q <= `SCLC_WIDTH_RESET;
            int_mask_q  <= {`SCLC_INT_W{1'b0}};
        end
        else if (wr_en)
        begin
            case (paddr)
                `SCLC_ADDR_CTRL:
                begin
                    logon_q   <= pwdata[`SCLC_CTRL_LOGON];
                    // Monitoring needs the log-on bit set in the same write
                    monitor_q <= pwdata[`SCLC_CTRL_MONITOR] &
                                 pwdata[`SCLC_CTRL_LOGON];          // [RQ4]
                    pole_q    <= pwdata[`SCLC_CTRL_POLE];
                end
                `SCLC_ADDR_CFG:
                begin
                    cfg_pend_q <= pwdata[7:0];                      // [RQ7]
                    pending_q  <= 1'b1;
                end
                `SCLC_ADDR_CONFIRM:
                    if (pwdata[0] && pending_q)
                    begin
                        cfg_q     <= cfg_pend_q;                    // [RQ7]
                        pending_q <= 1'b0;
                    end
                `SCLC_ADDR_WIDTH:
                begin
                    width_one_q <= clamp_width(pwdata[4:0]);        // [RQ17]
                    width_two_q <= clamp_width(pwdata[12:8]);       // [RQ17]
                end
                `SCLC_ADDR_INT_MASK:
                    int_mask_q <= pwdata[`SCLC_INT_W-1:0];
                default:
                    logon_q <= logon_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, write one to clear, a new event beats the clear
    assign change_evt = active & pole_q & (summer_to_winter | winter_to_summer);
    assign events = {(|(line_fault & ~fault_q)), change_evt,
                     wr_en & (paddr == `SCLC_ADDR_CONFIRM) & pwdata[0] & pending_q};

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            int_stat_q <= {`SCLC_INT_W{1'b0}};
            fault_q    <= 2'b00;
        end
        else
        begin
            fault_q <= line_fault;
            if (wr_en && paddr == `SCLC_ADDR_INT_STAT)
                int_stat_q <= (int_stat_q & ~pwdata[`SCLC_INT_W-1:0]) | events;
            else
                int_stat_q <= int_stat_q | events;
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Send indicator: dark until active, lit on error, else blinks on bus use
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            send_led    <= 1'b0;
            blink_q     <= 23'h00_0000;
            blink_arm_q <= 1'b0;
        end
        else if (!active)
        begin
            send_led    <= 1'b0;                                    // [RQ5]
            blink_q     <= 23'h00_0000;
            blink_arm_q <= 1'b0;
        end
        else if (board_error)
            send_led <= 1'b1;                                       // [RQ6]
        else
        begin
            if (psel && penable)
                blink_arm_q <= 1'b1;
            if (blink_q != 23'h00_0000)
                blink_q <= blink_q - 23'd1;
            else if (blink_arm_q)
            begin
                blink_arm_q <= 1'b0;
                blink_q     <= 23'h7F_FFFF;
                send_led    <= 1'b1;
            end
            else
                send_led <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line roles and changeover handling
    assign h24_one    = cfg_q[`SCLC_CFG_H24_ONE];                   // [RQ8]
    assign h24_two    = cfg_q[`SCLC_CFG_H24_TWO];                   // [RQ9]
    assign is_h24     = {h24_two, h24_one};
    assign is_minute  = {cfg_q[`SCLC_CFG_TWO_MIN], 1'b1};           // [RQ10]
    assign lines_used = cfg_q[`SCLC_CFG_TWO_MIN] ? 2'd2 : 2'd1;     // [RQ11]

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_line
            // Hold also forced in 24h so the pulse backlog cannot overrun
            assign fwd_hold[g]   = ~cfg_q[`SCLC_CFG_UPDATE] | is_h24[g];   // [RQ14]
            assign line_en[g]    = active & pole_q;                        // [RQ16]
            assign line_tick[g]  = is_minute[g] ? minute_tick : second_tick;
            assign line_width[g] = is_minute[g] ?
                                   (g == 0 ? width_one_q : width_two_q) :
                                   `SCLC_WIDTH_SECOND;                     // [RQ17]

            always @*
            begin
                add_req[g]    = 1'b0;
                skip_req[g]   = 1'b0;
                change_cnt[g] = `SCLC_HOUR_MIN;
                if (is_minute[g] && fwd_hold[g])
                begin
                    skip_req[g] = summer_to_winter;                        // [RQ12]
                    add_req[g]  = winter_to_summer;                        // [RQ12]
                end
                else if (is_minute[g])
                begin
                    add_req[g] = summer_to_winter | winter_to_summer;      // [RQ13]
                    if (summer_to_winter)
                        change_cnt[g] = is_h24[g] ? `SCLC_FORERUN24_MIN :
                                                    `SCLC_FORERUN12_MIN;   // [RQ13]
                end
            end

            sclc_pulse_line #(
                .TENTH_CYCLES (TENTH_CYCLES)
            ) u_line (
                .core_clk     (core_clk),
                .srst         (srst),
                .enable       (line_en[g]),
                .tick         (line_tick[g]),
                .width_tenths (line_width[g]),
                .add_req      (add_req[g]),
                .skip_req     (skip_req[g]),
                .change_cnt   (change_cnt[g]),
                .busy         (),
                .drive_pos    (drv_pos[g]),
                .drive_neg    (drv_neg[g])
            );
        end
    endgenerate

    assign {pulse_line_two_pos, pulse_line_one_pos} = drv_pos;
    assign {pulse_line_two_neg, pulse_line_one_neg} = drv_neg;

endmodule

`default_nettype wire

// *** dv/sclc_top_asserts.sv ***
`default_nettype none
module sclc_top_asserts #(
    parameter int TENTH_CYCLES = 4
) (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        pulse_line_one_pos,
    input wire logic        pulse_line_one_neg,
    input wire logic        pulse_line_two_pos,
    input wire logic        pulse_line_two_neg,
    input wire logic        send_led,
    input wire logic [1:0]  lines_used,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    wire         on1 = pulse_line_one_pos | pulse_line_one_neg;
    wire         on2 = pulse_line_two_pos | pulse_line_two_neg;
    logic [1:0]  pol1_q;
    logic [1:0]  pol2_q;
    logic [15:0] hi1_q;
    logic [15:0] hi2_q;
    ////////////////////////////////////////////////////////////////////////
    // Cleared in reset so nothing stale fires
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pol1_q <= 2'h0;
            pol2_q <= 2'h0;
            hi1_q  <= 16'h0;
            hi2_q  <= 16'h0;
        end
        else
        begin
            if (on1)
                pol1_q <= {pulse_line_one_neg, pulse_line_one_pos};
            if (on2)
                pol2_q <= {pulse_line_two_neg, pulse_line_two_pos};
            hi1_q <= on1 ? hi1_q + 16'h1 : 16'h0;
            hi2_q <= on2 ? hi2_q + 16'h1 : 16'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    sequence one_starts;
        $rose(on1);
    endsequence
    sequence two_starts;
        $rose(on2);
    endsequence
    sequence one_ends;
        $fell(on1);
    endsequence
    sequence second_ends;
        $fell(on2) && lines_used == 2'h1;
    endsequence
    ready_always_a: assert property (pready)
        else $error("pready low");
    slverr_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    unmapped_err_a: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 8'h1C))
        else $error("pslverr wrong");
    reset_quiet_a: assert property ($fell(srst) |-> !on1 && !on2 && !irq && !send_led
        && prdata == 32'h0 && lines_used == 2'h1)
        else $error("not quiet after reset");
    polarity_excl_a: assert property (!(pulse_line_one_pos && pulse_line_one_neg)
        && !(pulse_line_two_pos && pulse_line_two_neg))
        else $error("both polarities driven");
    one_alternate_a: assert property (one_starts
        |-> pol1_q != {pulse_line_one_neg, pulse_line_one_pos})
        else $error("line one repeat");
    two_alternate_a: assert property (two_starts
        |-> pol2_q != {pulse_line_two_neg, pulse_line_two_pos})
        else $error("line two repeat");
    minute_width_a: assert property (one_ends
        |-> hi1_q >= 2 * TENTH_CYCLES && hi1_q <= 30 * TENTH_CYCLES)
        else $error("line one width");
    second_width_a: assert property (second_ends |-> hi2_q == 2 * TENTH_CYCLES)
        else $error("second width");
    lines_count_a: assert property (lines_used == 2'h1 || lines_used == 2'h2)
        else $error("lines_used illegal");
endmodule
bind sclc_top sclc_top_asserts #(.TENTH_CYCLES(TENTH_CYCLES)) sclc_top_asserts_i (.*);
`default_nettype wire

// *** dv/sclc_clock_chain.sv ***
`default_nettype none
module sclc_clock_chain (
    input  wire logic core_clk,
    input  wire logic drive_pos,
    input  wire logic drive_neg,
    output var  int   steps = 0,
    output var  int   last_width = 0,
    output var  int   bad_turns = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    int   run = 0;
    logic last_neg = 1'b0;
    // Clockwork steps on its first pulse, then only on a polarity change
    always @(posedge core_clk)
    begin
        if (drive_pos | drive_neg)
        begin
            if (run == 0)
            begin
                if (steps == 0 || drive_neg !== last_neg)
                    steps <= steps + 1;
                else
                    bad_turns <= bad_turns + 1;
                last_neg <= drive_neg;
            end
            run <= run + 1;
        end
        else
        begin
            if (run > 0)
                last_width <= run;
            run <= 0;
        end
    end
endmodule
`default_nettype wire

// *** dv/sclc_top_tb.sv ***
`include "sclc_regs.vh"
`default_nettype none
module sclc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  sw = 8'h00;
    logic [3:0]  ev = 4'h0;
    logic [1:0]  fault = 2'h0;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  pl;
    logic        send_led;
    logic [1:0]  lines_used;
    logic        irq;
    int          n_fail = 0;
    int          checks_done = 0;
    int          e1 = 0;
    int          e2 = 0;
    int          s1, s2, w1, w2, b1, b2;
    logic [4:0]  nums[5] = '{5'd0, 5'd1, 5'd16, 5'd31, 5'd5};
    logic [7:0]  cfgs[3] = '{8'h60, 8'hE0, 8'h70};
    sclc_top #(.TENTH_CYCLES(TC)) sclc_top_i (
        .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .board_number_switch_bank(sw),
        .minute_tick(ev[0]), .second_tick(ev[1]), .summer_to_winter(ev[2]),
        .winter_to_summer(ev[3]), .line_fault(fault),
        .pulse_line_one_pos(pl[0]), .pulse_line_one_neg(pl[1]),
        .pulse_line_two_pos(pl[2]), .pulse_line_two_neg(pl[3]),
        .send_led(send_led), .lines_used(lines_used), .irq(irq));
    sclc_clock_chain chain_one_i (.core_clk(core_clk), .drive_pos(pl[0]),
        .drive_neg(pl[1]), .steps(s1), .last_width(w1), .bad_turns(b1));
    sclc_clock_chain chain_two_i (.core_clk(core_clk), .drive_pos(pl[2]),
        .drive_neg(pl[3]), .steps(s2), .last_width(w2), .bad_turns(b2));
    always #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Starts at the next edge; calls leave one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [32:0] q);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        q = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
        begin
            chk(1'b0, 1'b1, "no pready");
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q & {1'b1, m}, {1'b0, e}, $sformatf("read %h", a));
    endtask
    task automatic fire(input int n, input logic [3:0] v);
        repeat (n)
        begin
            @(posedge core_clk);
            ev <= v;
            @(posedge core_clk);
            ev <= 4'h0;
        end
    endtask
    task automatic steps_are(input int d1, input int d2);
        int k;
        e1 += d1;
        e2 += d2;
        for (k = 0; k < 40000 && (s1 < e1 || s2 < e2); k++)
            @(posedge core_clk);
        repeat (200) @(posedge core_clk);
        chk(s1, e1, "line one steps");
        chk(s2, e2, "line two steps");
        if (k == 40000)
            tally_and_finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [32:0] q;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        rd(`SCLC_ADDR_CFG, 32'hFF, 32'h00);
        rd(`SCLC_ADDR_CTRL, 32'h7, 32'h4);
        rd(`SCLC_ADDR_WIDTH, 32'h1F1F, 32'h0202);
        foreach (nums[i])
        begin
            sw <= {nums[i][0], nums[i][1], nums[i][2], nums[i][3], nums[i][4], 3'h7};
            rd(`SCLC_ADDR_ID, 32'h1F, {27'h0, nums[i]});
            rd(`SCLC_ADDR_STATUS, 32'h4, {29'h0, nums[i] != 5'd0, 2'h0});
        end
        fire(3, 4'h1);
        steps_are(0, 0);
        rd(`SCLC_ADDR_STATUS, 32'h8, 32'h0);
        chk(send_led, 1'b0, "led while idle");
        wr(`SCLC_ADDR_CTRL, 32'h6);
        rd(`SCLC_ADDR_STATUS, 32'h1, 32'h0);
        wr(`SCLC_ADDR_WIDTH, 32'h1F01);
        rd(`SCLC_ADDR_WIDTH, 32'h1F1F, 32'h1E02);
        wr(`SCLC_ADDR_WIDTH, 32'h0A05);
        wr(`SCLC_ADDR_CTRL, 32'h7);
        rd(`SCLC_ADDR_STATUS, 32'hF, 32'hD);
        fire(3, 4'h1);
        steps_are(3, 0);
        chk(w1, 5 * TC, "minute width");
        fire(2, 4'h2);
        steps_are(0, 2);
        chk(w2, 2 * TC, "second width");
        wr(`SCLC_ADDR_CFG, 32'h40);
        rd(`SCLC_ADDR_CFG, 32'hFF, 32'h00);
        rd(`SCLC_ADDR_STATUS, 32'h70, 32'h30);
        wr(`SCLC_ADDR_CONFIRM, 32'h1);
        rd(`SCLC_ADDR_STATUS, 32'h70, 32'h40);
        chk(lines_used, 2'h2, "two lines");
        @(negedge core_clk);
        chk(irq, 1'b0, "irq masked");
        wr(`SCLC_ADDR_INT_MASK, 32'h1);
        @(negedge core_clk);
        chk(irq, 1'b1, "irq raised");
        wr(`SCLC_ADDR_INT_STAT, 32'h1);
        rd(`SCLC_ADDR_INT_STAT, 32'h1, 32'h0);
        chk(irq, 1'b0, "irq cleared");
        fault <= 2'h1;
        rd(`SCLC_ADDR_STATUS, 32'h2, 32'h2);
        chk(send_led, 1'b1, "led on error");
        rd(`SCLC_ADDR_INT_STAT, 32'h4, 32'h4);
        fault <= 2'h0;
        wr(`SCLC_ADDR_INT_STAT, 32'h7);
        fire(1, 4'h4);
        fire(60, 4'h1);
        steps_are(0, 0);
        fire(1, 4'h1);
        steps_are(1, 1);
        fire(1, 4'h8);
        steps_are(60, 60);
        rd(`SCLC_ADDR_INT_STAT, 32'h2, 32'h2);
        wr(`SCLC_ADDR_WIDTH, 32'h0202);
        foreach (cfgs[i])
        begin
            wr(`SCLC_ADDR_CFG, {24'h0, cfgs[i]});
            wr(`SCLC_ADDR_CONFIRM, 32'h1);
            fire(1, 4'h4);
            fire(60, 4'h1);
            steps_are(cfgs[i][7] ? 0 : 720, cfgs[i][4] ? 0 : 720);
        end
        wr(`SCLC_ADDR_CTRL, 32'h3);
        fire(2, 4'h3);
        steps_are(0, 0);
        apb(1'b0, 8'h40, 32'h0, q);
        chk(q, 33'h1_0000_0000, "unmapped read");
        chk(b1 + b2, 0, "repeated polarity");
        tally_and_finish;
    end
endmodule
`default_nettype wire
